// ===== shared/tbtc_pkg.sv
`default_nettype none
package tbtc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // bus geometry and register byte offsets
  localparam int         TBTC_ADDR_W          = 8;
  localparam logic [7:0] TBTC_OFF_CTRL_EVEN   = 8'h00;
  localparam logic [7:0] TBTC_OFF_COUNT_EVEN  = 8'h04;
  localparam logic [7:0] TBTC_OFF_PERIOD_EVEN = 8'h08;
  localparam logic [7:0] TBTC_OFF_CTRL_ODD    = 8'h10;
  localparam logic [7:0] TBTC_OFF_COUNT_ODD   = 8'h14;
  localparam logic [7:0] TBTC_OFF_PERIOD_ODD  = 8'h18;

  ////////////////////////////////////////////////////////////////////////////
  // timer_control field positions
  localparam int TBTC_BIT_ON     = 15;
  localparam int TBTC_BIT_STOP_IN_IDLE   = 13;
  localparam int TBTC_BIT_GATE   = 7;
  localparam int TBTC_BIT_PS_LSB = 4;
  localparam int TBTC_BIT_WIDE   = 3;
  localparam int TBTC_BIT_TCS    = 1;

  ////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [31:0] TBTC_CTRL_RESET   = 32'h00000000;
  localparam logic [15:0] TBTC_COUNT_RESET  = 16'h0000;
  localparam logic [15:0] TBTC_PERIOD_RESET = 16'hFFFF;

  ////////////////////////////////////////////////////////////////////////////
  // control fields of one timer
  typedef struct packed {
    logic       on;
    logic       stop_in_idle;
    logic       gate_accumulate_enable;
    logic [2:0] input_prescale_select;
    logic       pair_wide_mode;
    logic       clock_source_select;
  } tbtc_ctrl_s;

  // bus word to control fields; pairing bit kept only for the even timer
  function automatic tbtc_ctrl_s tbtc_unpack(input logic [31:0] w, input logic even);
    tbtc_ctrl_s c;
    c.on                     = w[TBTC_BIT_ON];
    c.stop_in_idle           = w[TBTC_BIT_STOP_IN_IDLE];
    c.gate_accumulate_enable = w[TBTC_BIT_GATE];
    c.input_prescale_select  = w[TBTC_BIT_PS_LSB +: 3];
    c.pair_wide_mode         = w[TBTC_BIT_WIDE] & even;
    c.clock_source_select    = w[TBTC_BIT_TCS];
    return c;
  endfunction

  // control fields to bus word; gate bit reads zero under the external clock
  function automatic logic [31:0] tbtc_pack(input tbtc_ctrl_s c);
    logic [31:0] w;
    w                      = 32'h00000000;
    w[TBTC_BIT_ON]         = c.on;
    w[TBTC_BIT_STOP_IN_IDLE]       = c.stop_in_idle;
    w[TBTC_BIT_GATE]       = c.gate_accumulate_enable & ~c.clock_source_select;
    w[TBTC_BIT_PS_LSB +: 3] = c.input_prescale_select;
    w[TBTC_BIT_WIDE]       = c.pair_wide_mode;
    w[TBTC_BIT_TCS]        = c.clock_source_select;
    return w;
  endfunction

  // last prescaler count for each ratio code (ratio minus one)
  function automatic logic [7:0] tbtc_prescale_last(input logic [2:0] sel);
    case (sel)
      3'h0:    return 8'h00;
      3'h1:    return 8'h01;
      3'h2:    return 8'h03;
      3'h3:    return 8'h07;
      3'h4:    return 8'h0F;
      3'h5:    return 8'h1F;
      3'h6:    return 8'h3F;
      default: return 8'hFF;
    endcase
  endfunction

endpackage
`default_nettype wire

// ===== hdl/tbtc_prescale.sv
`timescale 1ns/1ps
`default_nettype none
module tbtc_prescale (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       clear,
  input  wire logic       tick_in,
  input  wire logic [2:0] sel,
  output var  logic       tick_out
);
  import tbtc_pkg::*;

  logic [7:0] cnt;
  logic [7:0] next_cnt;
  logic       next_tick;

  ////////////////////////////////////////////////////////////////////////////
  // divide input ticks by the selected ratio
  always_comb
  begin
    next_cnt  = cnt;
    next_tick = 1'b0;
    if (clear)
    begin
      next_cnt = 8'h00;
    end
    else if (tick_in)
    begin
      if (cnt >= tbtc_prescale_last(sel)) // (R5)
      begin
        next_cnt  = 8'h00;
        next_tick = 1'b1;
      end
      else
      begin
        next_cnt = cnt + 8'h01;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt      <= 8'h00;
      tick_out <= 1'b0;
    end
    else
    begin
      cnt      <= next_cnt;
      tick_out <= next_tick;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  property p_tick_cause;
    @(posedge pclk) disable iff (!presetn)
    tick_out |-> $past(tick_in) && !$past(clear);
  endproperty
  a_tick_cause: assert property (p_tick_cause) else $error("prescaler tick without input"); // (R5)

  property p_div_one;
    @(posedge pclk) disable iff (!presetn)
    (sel == 3'h0) && tick_in && !clear |=> tick_out;
  endproperty
  a_div_one: assert property (p_div_one) else $error("ratio one did not pass tick"); // (R5)

endmodule
`default_nettype wire

// ===== hdl/tbtc_timer_pair.sv
// Functional notes
// (R1) on bit 15 enables the timer module
// (R2) stop-in-idle bit 13 halts timer in Idle
// (R3) external clock: gate bit ignored, reads zero
// (R4) internal clock: gate bit counts only gate-high
// (R5) prescale bits 6:4 divide 1..256
// (R6) pairing bit exists only in even timer
// (R7) paired: odd timer settings have no effect
// (R8) software clears odd stop-in-idle for paired Idle
// (R9) software avoids access right after clearing on
// (R10) timer clocked from the peripheral bus clock
// (R11) Idle halts only peripherals with stop-in-idle set
// (R12) clock select: one external pin, zero bus clock
//
// Chosen here: the register addresses and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module tbtc_timer_pair (
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [tbtc_pkg::TBTC_ADDR_W-1:0] paddr,
  input  wire logic [31:0]                   pwdata,
  output var  logic [31:0]                   prdata,
  output var  logic                          pready,
  output var  logic                          pslverr,
  input  wire logic                          idle_mode,
  input  wire logic                          ext_clk_even,
  input  wire logic                          ext_clk_odd,
  input  wire logic                          gate_even,
  input  wire logic                          gate_odd,
  output var  logic                          match_even,
  output var  logic                          match_odd
);
  import tbtc_pkg::*;

  tbtc_ctrl_s  ctrl_e;
  tbtc_ctrl_s  ctrl_o;
  tbtc_ctrl_s  next_ctrl_e;
  tbtc_ctrl_s  next_ctrl_o;
  logic [15:0] per_e;
  logic [15:0] per_o;
  logic [15:0] next_per_e;
  logic [15:0] next_per_o;
  logic [15:0] cnt_e;
  logic [15:0] cnt_o;
  logic [15:0] next_cnt_e;
  logic [15:0] next_cnt_o;
  logic        next_match_e;
  logic        next_match_o;
  logic [3:0]  sync1;
  logic [3:0]  sync2;
  logic [3:0]  sync_prev;
  logic [31:0] next_prdata;
  logic        next_pready;
  logic        next_pslverr;
  logic        setup;
  logic        wr_en;
  logic        mapped;
  logic        wr_ctrl_e;
  logic        wr_ctrl_o;
  logic        wr_cnt_e;
  logic        wr_cnt_o;
  logic        wide;
  logic        run_e;
  logic        run_o;
  logic        src_e;
  logic        src_o;
  logic        pre_in_e;
  logic        pre_in_o;
  logic        tick_e;
  logic        tick_o;
  logic        inc_e;
  logic        inc_o;
  logic [31:0] cnt32;
  logic [31:0] per32;
  logic [31:0] sum32;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: {gate_odd, gate_even, ext_clk_odd, ext_clk_even}
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync1     <= 4'h0;
      sync2     <= 4'h0;
      sync_prev <= 4'h0;
    end
    else
    begin
      sync1     <= {gate_odd, gate_even, ext_clk_odd, ext_clk_even};
      sync2     <= sync1;
      sync_prev <= sync2;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb decode
  assign setup  = psel && !penable;
  assign wr_en  = psel && penable && pready && pwrite && !pslverr;
  assign mapped = (paddr == TBTC_OFF_CTRL_EVEN) || (paddr == TBTC_OFF_COUNT_EVEN) ||
                  (paddr == TBTC_OFF_PERIOD_EVEN) || (paddr == TBTC_OFF_CTRL_ODD) ||
                  (paddr == TBTC_OFF_COUNT_ODD) || (paddr == TBTC_OFF_PERIOD_ODD);
  assign wr_ctrl_e = wr_en && (paddr == TBTC_OFF_CTRL_EVEN);
  assign wr_ctrl_o = wr_en && (paddr == TBTC_OFF_CTRL_ODD);
  assign wr_cnt_e  = wr_en && (paddr == TBTC_OFF_COUNT_EVEN);
  assign wr_cnt_o  = wr_en && (paddr == TBTC_OFF_COUNT_ODD);

  // answer in the first access cycle; read data latched at setup
  always_comb
  begin
    next_pready  = setup;
    next_pslverr = setup && !mapped;
    next_prdata  = prdata;
    if (setup && !pwrite)
    begin
      case (paddr)
        TBTC_OFF_CTRL_EVEN:   next_prdata = tbtc_pack(ctrl_e); // (R3)
        TBTC_OFF_COUNT_EVEN:  next_prdata = {16'h0000, cnt_e};
        TBTC_OFF_PERIOD_EVEN: next_prdata = {16'h0000, per_e};
        TBTC_OFF_CTRL_ODD:    next_prdata = tbtc_pack(ctrl_o); // (R3)
        TBTC_OFF_COUNT_ODD:   next_prdata = {16'h0000, cnt_o};
        TBTC_OFF_PERIOD_ODD:  next_prdata = {16'h0000, per_o};
        default:              next_prdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      prdata  <= next_prdata;
      pready  <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control and period registers
  always_comb
  begin
    next_ctrl_e = ctrl_e;
    next_ctrl_o = ctrl_o;
    next_per_e  = per_e;
    next_per_o  = per_o;
    if (wr_ctrl_e)
    begin
      next_ctrl_e = tbtc_unpack(pwdata, 1'b1); // (R6)
    end
    if (wr_ctrl_o)
    begin
      next_ctrl_o = tbtc_unpack(pwdata, 1'b0); // (R6)
    end
    if (wr_en && (paddr == TBTC_OFF_PERIOD_EVEN))
    begin
      next_per_e = pwdata[15:0];
    end
    if (wr_en && (paddr == TBTC_OFF_PERIOD_ODD))
    begin
      next_per_o = pwdata[15:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_e <= tbtc_unpack(TBTC_CTRL_RESET, 1'b1);
      ctrl_o <= tbtc_unpack(TBTC_CTRL_RESET, 1'b0);
      per_e  <= TBTC_PERIOD_RESET;
      per_o  <= TBTC_PERIOD_RESET;
    end
    else
    begin
      ctrl_e <= next_ctrl_e;
      ctrl_o <= next_ctrl_o;
      per_e  <= next_per_e;
      per_o  <= next_per_o;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // run qualification and tick sources
  assign wide  = ctrl_e.pair_wide_mode;
  assign run_e = ctrl_e.on && !(idle_mode && ctrl_e.stop_in_idle) && // (R1) (R2) (R11)
                 !(wide && idle_mode && ctrl_o.stop_in_idle); // (R8)
  assign run_o = !wide && ctrl_o.on && !(idle_mode && ctrl_o.stop_in_idle); // (R7) (R11)
  // external pin rising edge, or bus clock with optional gate
  assign src_e = ctrl_e.clock_source_select ? (sync2[0] && !sync_prev[0]) : // (R12)
                 (!ctrl_e.gate_accumulate_enable || sync2[2]); // (R3) (R4)
  assign src_o = ctrl_o.clock_source_select ? (sync2[1] && !sync_prev[1]) : // (R12)
                 (!ctrl_o.gate_accumulate_enable || sync2[3]); // (R3) (R4)
  assign pre_in_e = run_e && src_e;
  assign pre_in_o = run_o && src_o;

  // prescalers run on the peripheral bus clock
  tbtc_prescale u_pre_even (
    .pclk     (pclk),
    .presetn  (presetn),
    .clear    (!ctrl_e.on || wr_ctrl_e),
    .tick_in  (pre_in_e),
    .sel      (ctrl_e.input_prescale_select),
    .tick_out (tick_e)
  );

  tbtc_prescale u_pre_odd (
    .pclk     (pclk),
    .presetn  (presetn),
    .clear    (wide || !ctrl_o.on || wr_ctrl_o), // (R7)
    .tick_in  (pre_in_o),
    .sel      (ctrl_o.input_prescale_select),
    .tick_out (tick_o)
  );

  ////////////////////////////////////////////////////////////////////////////
  // counters; a pending tick is dropped once the timer stops
  assign inc_e = tick_e && run_e; // (R1) (R2)
  assign inc_o = tick_o && run_o;
  assign cnt32 = {cnt_o, cnt_e};
  assign per32 = {per_o, per_e};
  assign sum32 = cnt32 + 32'h00000001;

  always_comb
  begin
    next_cnt_e   = cnt_e;
    next_cnt_o   = cnt_o;
    next_match_e = 1'b0;
    next_match_o = 1'b0;
    if (wide)
    begin
      if (inc_e) // (R7)
      begin
        if (cnt32 == per32)
        begin
          next_cnt_e   = TBTC_COUNT_RESET;
          next_cnt_o   = TBTC_COUNT_RESET;
          next_match_o = 1'b1;
        end
        else
        begin
          next_cnt_e = sum32[15:0];
          next_cnt_o = sum32[31:16];
        end
      end
    end
    else
    begin
      if (inc_e)
      begin
        next_match_e = (cnt_e == per_e);
        next_cnt_e   = next_match_e ? TBTC_COUNT_RESET : cnt_e + 16'h0001;
      end
      if (inc_o)
      begin
        next_match_o = (cnt_o == per_o);
        next_cnt_o   = next_match_o ? TBTC_COUNT_RESET : cnt_o + 16'h0001;
      end
    end
    if (wr_cnt_e)
    begin
      next_cnt_e = pwdata[15:0];
    end
    if (wr_cnt_o)
    begin
      next_cnt_o = pwdata[15:0];
    end
  end

  // all timer state on pclk
  always_ff @(posedge pclk or negedge presetn) // (R10)
  begin
    if (!presetn)
    begin
      cnt_e      <= TBTC_COUNT_RESET;
      cnt_o      <= TBTC_COUNT_RESET;
      match_even <= 1'b0;
      match_odd  <= 1'b0;
    end
    else
    begin
      cnt_e      <= next_cnt_e;
      cnt_o      <= next_cnt_o;
      match_even <= next_match_e;
      match_odd  <= next_match_o;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable;
  endsequence

  property p_apb_ready;
    s_setup ##1 s_access |-> pready;
  endproperty
  a_apb_ready: assert property (p_apb_ready) else $error("no ready in access"); // (R10)

  property p_off_hold;
    !ctrl_e.on && !wr_cnt_e |=> cnt_e == $past(cnt_e);
  endproperty
  a_off_hold: assert property (p_off_hold) else $error("counted while disabled"); // (R1)

  property p_idle_hold;
    idle_mode && ctrl_e.stop_in_idle && !wr_cnt_e |=> cnt_e == $past(cnt_e);
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("counted in idle"); // (R2)

  property p_gate_read;
    s_setup and (!pwrite && (paddr == TBTC_OFF_CTRL_EVEN) && ctrl_e.clock_source_select)
      |=> prdata[TBTC_BIT_GATE] == 1'b0;
  endproperty
  a_gate_read: assert property (p_gate_read) else $error("gate bit read nonzero"); // (R3)

  property p_gate_block;
    !ctrl_e.clock_source_select && ctrl_e.gate_accumulate_enable && !sync2[2] |-> !pre_in_e;
  endproperty
  a_gate_block: assert property (p_gate_block) else $error("counted with gate low"); // (R4)

  property p_odd_no_wide;
    !ctrl_o.pair_wide_mode;
  endproperty
  a_odd_no_wide: assert property (p_odd_no_wide) else $error("odd pairing bit set"); // (R6)

  property p_wide_carry;
    wide && inc_e && (cnt32 != per32) && !wr_cnt_e && !wr_cnt_o
      |=> {cnt_o, cnt_e} == $past(sum32);
  endproperty
  a_wide_carry: assert property (p_wide_carry) else $error("paired count wrong"); // (R7)

  property p_wide_odd_idle;
    wide && idle_mode && ctrl_o.stop_in_idle && !wr_cnt_e |=> cnt_e == $past(cnt_e);
  endproperty
  a_wide_odd_idle: assert property (p_wide_odd_idle) else $error("pair ran in idle"); // (R8)

  property p_wrap_match;
    !wide && inc_e && (cnt_e == per_e) |=> match_even && ($past(wr_cnt_e) || (cnt_e == 16'h0000));
  endproperty
  a_wrap_match: assert property (p_wrap_match) else $error("wrap without match"); // (R1)

endmodule
`default_nettype wire

// ===== verif/tbtc_timer_pair_tb.sv
`timescale 1ns/1ps
`default_nettype none
module tbtc_timer_pair_tb;
  import tbtc_pkg::*;

  localparam logic [31:0] C_ON   = 32'h00008000;
  localparam logic [31:0] C_STOP_IN_IDLE = 32'h00002000;
  localparam logic [31:0] C_GATE = 32'h00000080;
  localparam logic [31:0] C_PAIR = 32'h00000008;
  localparam logic [31:0] C_TCS  = 32'h00000002;

  logic                   pclk         = 1'b0;
  logic                   presetn      = 1'b0;
  logic                   psel         = 1'b0;
  logic                   penable      = 1'b0;
  logic                   pwrite       = 1'b0;
  logic [TBTC_ADDR_W-1:0] paddr        = '0;
  logic [31:0]            pwdata       = 32'h00000000;
  logic [31:0]            prdata;
  logic                   pready;
  logic                   pslverr;
  logic                   idle_mode    = 1'b0;
  logic                   ext_clk_even = 1'b0;
  logic                   ext_clk_odd  = 1'b0;
  logic                   gate_even    = 1'b0;
  logic                   gate_odd     = 1'b0;
  logic                   match_even;
  logic                   match_odd;
  logic [31:0]            rdat;
  logic                   rerr;
  logic [31:0]            a0;
  logic [31:0]            w;
  int                     num_errors   = 0;
  int                     check_count  = 0;
  int                     n;

  ////////////////////////////////////////////////////////////////////////////
  // clock and odd-side pin noise that paired mode must ignore
  always #5 pclk = ~pclk;

  always @(posedge pclk)
  begin
    ext_clk_odd <= 1'($urandom);
    gate_odd    <= 1'($urandom);
  end

  tbtc_timer_pair tbtc_timer_pair_i (
    .pclk         (pclk),
    .presetn      (presetn),
    .psel         (psel),
    .penable      (penable),
    .pwrite       (pwrite),
    .paddr        (paddr),
    .pwdata       (pwdata),
    .prdata       (prdata),
    .pready       (pready),
    .pslverr      (pslverr),
    .idle_mode    (idle_mode),
    .ext_clk_even (ext_clk_even),
    .ext_clk_odd  (ext_clk_odd),
    .gate_even    (gate_even),
    .gate_odd     (gate_odd),
    .match_even   (match_even),
    .match_odd    (match_odd)
  );

  ////////////////////////////////////////////////////////////////////////////
  // expected control readback: gate reads zero under external clock
  function automatic logic [31:0] ctrl_exp(input logic [31:0] v, input logic even);
    logic [31:0] r;
    r      = 32'h00000000;
    r[15]  = v[15];
    r[13]  = v[13];
    r[7]   = v[7] & ~v[1];
    r[6:4] = v[6:4];
    r[3]   = v[3] & even;
    r[1]   = v[1];
    return r;
  endfunction

  // prescale ratio per code
  function automatic int ratio(input int c);
    return (c == 7) ? 256 : (1 << c);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // verdict and bus tasks
  task automatic final_report;
    if (num_errors == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
      num_errors++;
    end
  endtask

  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // pready, prdata and pslverr are read as sampled at this edge
    do
    begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20)
      num_errors++;
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h00000000);
    chk(nm, e, rdat);
  endtask

  // even count moves or holds over ten cycles
  task automatic moves(input logic e, input string nm);
    apb(1'b0, TBTC_OFF_COUNT_EVEN, 32'h00000000);
    a0 = rdat;
    repeat (10) @(posedge pclk);
    apb(1'b0, TBTC_OFF_COUNT_EVEN, 32'h00000000);
    chk(nm, {31'h0, e}, {31'h0, rdat !== a0});
  endtask

  task automatic ext_edges(input int k);
    repeat (k)
    begin
      @(posedge pclk);
      ext_clk_even <= 1'b1;
      repeat (3) @(posedge pclk);
      ext_clk_even <= 1'b0;
      repeat (3) @(posedge pclk);
    end
  endtask

  // cycles between two successive match pulses
  task automatic gap(input logic odd, output int g);
    int k;
    k = 0;
    @(posedge pclk);
    #1;
    while (((odd ? match_odd : match_even) !== 1'b1) && k < 3000)
    begin
      @(posedge pclk);
      #1;
      k++;
    end
    g = 0;
    do
    begin
      @(posedge pclk);
      #1;
      g++;
    end while (((odd ? match_odd : match_even) !== 1'b1) && g < 3000);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // watchdog
  initial
  begin
    #200000;
    num_errors++;
    final_report;
  end

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    void'($urandom(48399));
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rd(TBTC_OFF_CTRL_EVEN, TBTC_CTRL_RESET, "ctrl_even reset");
    rd(TBTC_OFF_CTRL_ODD, TBTC_CTRL_RESET, "ctrl_odd reset");
    rd(TBTC_OFF_COUNT_EVEN, 32'h00000000, "count_even reset");
    rd(TBTC_OFF_PERIOD_ODD, 32'h0000FFFF, "period_odd reset");
    rd(8'h0C, 32'h00000000, "unmapped data");
    chk("unmapped err", 32'h1, {31'h0, rerr});
    for (int i = 0; i < 8; i++)
    begin
      w = $urandom;
      apb(1'b1, TBTC_OFF_CTRL_EVEN, w);
      rd(TBTC_OFF_CTRL_EVEN, ctrl_exp(w, 1'b1), "ctrl_even rb");
      w = $urandom;
      apb(1'b1, TBTC_OFF_CTRL_ODD, w);
      rd(TBTC_OFF_CTRL_ODD, ctrl_exp(w, 1'b0), "ctrl_odd rb");
    end
    apb(1'b1, TBTC_OFF_CTRL_ODD, 32'h00000000);
    apb(1'b1, TBTC_OFF_CTRL_EVEN, 32'h00000000);
    w = $urandom & 32'h0000FFFF;
    apb(1'b1, TBTC_OFF_COUNT_EVEN, w);
    repeat (10) @(posedge pclk);
    rd(TBTC_OFF_COUNT_EVEN, w, "count while off");
    apb(1'b1, TBTC_OFF_CTRL_EVEN, C_ON);
    moves(1'b1, "count while on");
    idle_mode <= 1'b1;
    apb(1'b1, TBTC_OFF_CTRL_EVEN, C_ON | C_STOP_IN_IDLE);
    moves(1'b0, "idle with stop");
    apb(1'b1, TBTC_OFF_CTRL_EVEN, C_ON);
    moves(1'b1, "idle without stop");
    idle_mode <= 1'b0;
    apb(1'b1, TBTC_OFF_CTRL_EVEN, C_ON | C_GATE);
    moves(1'b0, "gate low");
    gate_even <= 1'b1;
    moves(1'b1, "gate high");
    gate_even <= 1'b0;
    apb(1'b1, TBTC_OFF_CTRL_EVEN, C_ON);
    moves(1'b1, "gate bit clear");
    apb(1'b1, TBTC_OFF_CTRL_EVEN, C_ON | C_TCS | C_GATE);
    moves(1'b0, "ext clock still");
    ext_edges(5);
    repeat (6) @(posedge pclk);
    rd(TBTC_OFF_COUNT_EVEN, (rdat + 32'd5) & 32'h0000FFFF, "ext edges");
    for (int c = 0; c < 8; c++)
    begin
      // an idle cycle always separates the disabling write from the next access
      apb(1'b1, TBTC_OFF_CTRL_EVEN, 32'h00000000);
      apb(1'b1, TBTC_OFF_COUNT_EVEN, 32'h00000000);
      apb(1'b1, TBTC_OFF_PERIOD_EVEN, 32'h00000001);
      apb(1'b1, TBTC_OFF_CTRL_EVEN, C_ON | (32'(c) << 4));
      gap(1'b0, n);
      chk("prescale gap", 32'(ratio(c) * 2), 32'(n));
    end
    apb(1'b1, TBTC_OFF_CTRL_EVEN, 32'h00000000);
    apb(1'b1, TBTC_OFF_COUNT_EVEN, 32'h00000000);
    apb(1'b1, TBTC_OFF_COUNT_ODD, 32'h00000000);
    apb(1'b1, TBTC_OFF_PERIOD_EVEN, 32'h00000003);
    apb(1'b1, TBTC_OFF_PERIOD_ODD, 32'h00000000);
    w = $urandom & ~C_STOP_IN_IDLE;
    apb(1'b1, TBTC_OFF_CTRL_ODD, w);
    apb(1'b1, TBTC_OFF_CTRL_EVEN, C_ON | C_PAIR);
    gap(1'b1, n);
    chk("pair gap", 32'd4, 32'(n));
    apb(1'b1, TBTC_OFF_PERIOD_EVEN, 32'h0000FFFF);
    idle_mode <= 1'b1;
    apb(1'b1, TBTC_OFF_CTRL_ODD, w | C_STOP_IN_IDLE);
    moves(1'b0, "pair idle odd stop");
    apb(1'b1, TBTC_OFF_CTRL_ODD, w);
    moves(1'b1, "pair idle run");
    idle_mode <= 1'b0;
    presetn <= 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rd(TBTC_OFF_CTRL_EVEN, TBTC_CTRL_RESET, "ctrl after reset");
    final_report;
  end

endmodule
`default_nettype wire
